// File: include/synth_latch_regs.vh
`ifndef SYNTH_LATCH_REGS_VH
`define SYNTH_LATCH_REGS_VH
// ****************************************
// latch select codes (low three bits)
// ****************************************
`define LATCH_SEL_LSB 0
`define LATCH_SEL_MSB 2
`define LATCH_INT_FRAC 3'h0
`define LATCH_MOD_PHASE 3'h1
`define LATCH_CTRL_TWO 3'h2
`define LATCH_CTRL_THREE 3'h3
`define LATCH_OUT_DIV 3'h4
`define LATCH_CTRL_FIVE 3'h5
// ****************************************
// integer_fraction_word fields
// ****************************************
`define FRAC_LSB 3
`define FRAC_MSB 14
`define INT_LSB 15
`define INT_MSB 30
// ****************************************
// modulus_phase_word fields
// ****************************************
`define MOD_LSB 3
`define MOD_MSB 14
`define PHASE_LSB 15
`define PHASE_MSB 26
// ****************************************
// control_word_two fields
// ****************************************
`define CP_CURRENT_LSB 9
`define CP_CURRENT_MSB 12
`define DBUF_DIV_BIT 13
`define REF_COUNT_LSB 14
`define REF_COUNT_MSB 23
`define REF_HALVE_BIT 24
`define REF_DOUBLER_BIT 25
`define TESTOUT_SEL_LSB 26
`define TESTOUT_SEL_MSB 28
// ****************************************
// output_divider_word fields
// ****************************************
`define OUT_POWER_LSB 3
`define OUT_POWER_MSB 4
`define AUX_ENABLE_BIT 8
`define MUTE_LOCK_BIT 10
`define BAND_DIV_LSB 12
`define BAND_DIV_MSB 19
`define OUT_DIV_LSB 20
`define OUT_DIV_MSB 22
`define FB_AFTER_DIV_BIT 23
// ****************************************
// reset values and timing counts
// ****************************************
`define WORD_RESET 32'h0000_0000
`define BAND_PFD_CYCLES 4'ha
`define TESTOUT_LOW 3'h0
`define TESTOUT_HIGH 3'h1
`define TESTOUT_GND 3'h2
`define TESTOUT_REF 3'h3
`define TESTOUT_FB 3'h4
`define TESTOUT_ALOCK 3'h5
`define TESTOUT_DLOCK 3'h6
`endif

// File: logic/serial_word_shifter.v
`timescale 1ns/100ps
`default_nettype none
`include "synth_latch_regs.vh"
module serial_word_shifter (
    input wire mclk_in,
    input wire resetn_in,
    input wire shift_en_in,
    input wire bit_in,
    output reg [31:0] word_out
);
    // msb first: each new bit enters at the bottom and moves up
    always @(posedge mclk_in) begin
        if (!resetn_in) begin
            word_out <= `WORD_RESET;
        end else if (shift_en_in) begin
            word_out <= {word_out[30:0], bit_in};
        end
    end
endmodule // serial_word_shifter
`default_nettype wire

// File: logic/band_select_timer.v
`timescale 1ns/100ps
`default_nettype none
`include "synth_latch_regs.vh"
module band_select_timer (
    input wire mclk_in,
    input wire resetn_in,
    input wire start_in,
    input wire pfd_tick_in,
    input wire [7:0] divider_in,
    output reg active_out
);
    reg [7:0] div_count;
    reg [3:0] band_cycles;
    wire [7:0] div_limit;
    // a ratio of zero is treated as one
    assign div_limit = (divider_in == 8'h00) ? 8'h01 : divider_in;
    // band clock = pfd ticks / divider; sequence lasts ten band clocks
    always @(posedge mclk_in) begin
        if (!resetn_in) begin
            div_count <= 8'h00;
            band_cycles <= 4'h0;
            active_out <= 1'b0;
        end else if (start_in) begin
            div_count <= 8'h00;
            band_cycles <= 4'h0;
            active_out <= 1'b1;
        end else if (active_out && pfd_tick_in) begin
            if (div_count + 8'h01 >= div_limit) begin
                div_count <= 8'h00;
                if (band_cycles + 4'h1 >= `BAND_PFD_CYCLES) begin
                    active_out <= 1'b0; // selection done
                end
                band_cycles <= band_cycles + 4'h1;
            end else begin
                div_count <= div_count + 8'h01;
            end
        end
    end
endmodule // band_select_timer
`default_nettype wire

// File: logic/synth_serial_program_latch.v
`timescale 1ns/100ps
`default_nettype none
`include "synth_latch_regs.vh"
module synth_serial_program_latch (
    input wire mclk_in,
    input wire resetn_in,
    input wire serial_clk_in,
    input wire serial_data_in,
    input wire latch_strobe_in,
    input wire ref_tick_in,
    input wire fb_tick_in,
    input wire digital_lock_in,
    input wire analog_lock_in,
    output reg [15:0] int_value_out,
    output reg [11:0] frac_value_out,
    output reg [11:0] modulus_out,
    output reg [11:0] phase_out,
    output reg [9:0] ref_count_out,
    output reg ref_doubler_out,
    output reg ref_halve_out,
    output reg [3:0] charge_current_out,
    output reg [2:0] output_divider_select_out,
    output reg [1:0] output_power_level_out,
    output reg aux_power_down_out,
    output reg feedback_after_divider_out,
    output reg rf_supply_enable_out,
    output reg lock_indicator_pin_out,
    output reg tune_to_reference_out,
    output reg test_output_pin_out,
    output reg [31:0] control_word_three_out,
    output reg [31:0] control_word_five_out
);
    // ****************************************
    // serial input capture
    // ****************************************
    reg serial_clk_prev;
    reg strobe_prev;
    wire shift_pulse;
    wire strobe_pulse;
    wire [31:0] shift_word;
    wire [2:0] latch_sel;

    // previous samples for edge detection
    always @(posedge mclk_in) begin
        if (!resetn_in) begin
            serial_clk_prev <= 1'b0;
            strobe_prev <= 1'b0;
        end else begin
            serial_clk_prev <= serial_clk_in;
            strobe_prev <= latch_strobe_in;
        end
    end

    assign shift_pulse = serial_clk_in & ~serial_clk_prev;
    assign strobe_pulse = latch_strobe_in & ~strobe_prev;
    assign latch_sel = shift_word[`LATCH_SEL_MSB:`LATCH_SEL_LSB];

    // 32-bit shift register
    serial_word_shifter u_shifter (
        .mclk_in(mclk_in),
        .resetn_in(resetn_in),
        .shift_en_in(shift_pulse),
        .bit_in(serial_data_in),
        .word_out(shift_word)
    );

    // ****************************************
    // latch write decode
    // ****************************************
    reg wr_int_frac;
    reg wr_mod_phase;
    reg wr_ctrl_two;
    reg wr_ctrl_three;
    reg wr_out_div;
    reg wr_ctrl_five;

    // one write strobe per latch; codes 6 and 7 hit nothing
    always @* begin
        wr_int_frac = 1'b0;
        wr_mod_phase = 1'b0;
        wr_ctrl_two = 1'b0;
        wr_ctrl_three = 1'b0;
        wr_out_div = 1'b0;
        wr_ctrl_five = 1'b0;
        if (strobe_pulse) begin
            if (latch_sel == `LATCH_INT_FRAC) begin
                wr_int_frac = 1'b1;
            end else if (latch_sel == `LATCH_MOD_PHASE) begin
                wr_mod_phase = 1'b1;
            end else if (latch_sel == `LATCH_CTRL_TWO) begin
                wr_ctrl_two = 1'b1;
            end else if (latch_sel == `LATCH_CTRL_THREE) begin
                wr_ctrl_three = 1'b1;
            end else if (latch_sel == `LATCH_OUT_DIV) begin
                wr_out_div = 1'b1;
            end else if (latch_sel == `LATCH_CTRL_FIVE) begin
                wr_ctrl_five = 1'b1;
            end else begin
                wr_ctrl_five = 1'b0;
            end
        end
    end

    // ****************************************
    // latches (pending copies of buffered fields)
    // ****************************************
    reg [11:0] pend_modulus;
    reg [11:0] pend_phase;
    reg [9:0] pend_ref_count;
    reg pend_doubler;
    reg pend_halve;
    reg [3:0] pend_current;
    reg [2:0] pend_divider;
    reg dbuf_divider;

    // latch one, two, four land in pending copies
    always @(posedge mclk_in) begin
        if (!resetn_in) begin
            pend_modulus <= 12'h000;
            pend_phase <= 12'h000;
            pend_ref_count <= 10'h001;
            pend_doubler <= 1'b0;
            pend_halve <= 1'b0;
            pend_current <= 4'h0;
            pend_divider <= 3'h0;
            dbuf_divider <= 1'b0;
        end else begin
            if (wr_mod_phase) begin
                pend_modulus <= shift_word[`MOD_MSB:`MOD_LSB];
                pend_phase <= shift_word[`PHASE_MSB:`PHASE_LSB];
            end
            if (wr_ctrl_two) begin
                pend_ref_count <= shift_word[`REF_COUNT_MSB:`REF_COUNT_LSB];
                pend_doubler <= shift_word[`REF_DOUBLER_BIT];
                pend_halve <= shift_word[`REF_HALVE_BIT];
                pend_current <= shift_word[`CP_CURRENT_MSB:`CP_CURRENT_LSB];
                dbuf_divider <= shift_word[`DBUF_DIV_BIT];
            end
            if (wr_out_div) begin
                pend_divider <= shift_word[`OUT_DIV_MSB:`OUT_DIV_LSB];
            end
        end
    end

    // ****************************************
    // active settings
    // ****************************************
    reg [2:0] testout_sel;
    reg [7:0] band_clock_divider;
    reg mute_until_locked;

    // buffered fields commit on a latch zero write
    always @(posedge mclk_in) begin
        if (!resetn_in) begin
            int_value_out <= 16'h0000;
            frac_value_out <= 12'h000;
            modulus_out <= 12'h000;
            phase_out <= 12'h000;
            ref_count_out <= 10'h001;
            ref_doubler_out <= 1'b0;
            ref_halve_out <= 1'b0;
            charge_current_out <= 4'h0;
            output_divider_select_out <= 3'h0;
        end else begin
            if (wr_int_frac) begin
                int_value_out <= shift_word[`INT_MSB:`INT_LSB];
                frac_value_out <= shift_word[`FRAC_MSB:`FRAC_LSB];
                modulus_out <= pend_modulus;
                phase_out <= pend_phase;
                ref_count_out <= pend_ref_count;
                ref_doubler_out <= pend_doubler;
                ref_halve_out <= pend_halve;
                charge_current_out <= pend_current;
            end
            // divider select: direct or via latch zero
            if (dbuf_divider) begin
                if (wr_int_frac) begin
                    output_divider_select_out <= pend_divider;
                end
            end else if (wr_out_div) begin
                output_divider_select_out <= shift_word[`OUT_DIV_MSB:`OUT_DIV_LSB];
            end
        end
    end

    // unbuffered fields take effect on their own write
    always @(posedge mclk_in) begin
        if (!resetn_in) begin
            testout_sel <= `TESTOUT_LOW;
            band_clock_divider <= 8'h01;
            mute_until_locked <= 1'b0;
            output_power_level_out <= 2'h0;
            aux_power_down_out <= 1'b1;
            feedback_after_divider_out <= 1'b0;
            control_word_three_out <= `WORD_RESET;
            control_word_five_out <= `WORD_RESET;
        end else begin
            if (wr_ctrl_two) begin
                testout_sel <= shift_word[`TESTOUT_SEL_MSB:`TESTOUT_SEL_LSB];
            end
            if (wr_out_div) begin
                band_clock_divider <= shift_word[`BAND_DIV_MSB:`BAND_DIV_LSB];
                mute_until_locked <= shift_word[`MUTE_LOCK_BIT];
                output_power_level_out <= shift_word[`OUT_POWER_MSB:`OUT_POWER_LSB];
                aux_power_down_out <= ~shift_word[`AUX_ENABLE_BIT];
                feedback_after_divider_out <= shift_word[`FB_AFTER_DIV_BIT];
            end
            if (wr_ctrl_three) begin
                control_word_three_out <= shift_word;
            end
            if (wr_ctrl_five) begin
                control_word_five_out <= shift_word;
            end
        end
    end

    // ****************************************
    // reference counter
    // ****************************************
    reg [9:0] ref_count;
    reg pfd_tick;
    reg ref_scaled;
    wire [9:0] ref_limit;

    // ratio 0 is treated as 1, so 1 to 1023 are honoured
    assign ref_limit = (ref_count_out == 10'h000) ? 10'h001 : ref_count_out;

    // divide reference ticks down to pfd ticks
    always @(posedge mclk_in) begin
        if (!resetn_in) begin
            ref_count <= 10'h000;
            pfd_tick <= 1'b0;
            ref_scaled <= 1'b0;
        end else begin
            pfd_tick <= 1'b0;
            if (ref_tick_in) begin
                if (ref_count + 10'h001 >= ref_limit) begin
                    ref_count <= 10'h000;
                    pfd_tick <= 1'b1;
                    ref_scaled <= ~ref_scaled;
                end else begin
                    ref_count <= ref_count + 10'h001;
                end
            end
        end
    end

    // ****************************************
    // band selection
    // ****************************************
    reg power_up_start;
    wire band_start;
    wire band_active;

    // one start pulse right after reset release
    always @(posedge mclk_in) begin
        if (!resetn_in) begin
            power_up_start <= 1'b1;
        end else begin
            power_up_start <= 1'b0;
        end
    end

    assign band_start = power_up_start | wr_int_frac;

    // ten band clocks of pfd ticks / divider
    band_select_timer u_band_timer (
        .mclk_in(mclk_in),
        .resetn_in(resetn_in),
        .start_in(band_start),
        .pfd_tick_in(pfd_tick),
        .divider_in(band_clock_divider),
        .active_out(band_active)
    );

    // ****************************************
    // lock, mute and tuning control
    // ****************************************
    reg fb_scaled;

    // registered status outputs
    always @(posedge mclk_in) begin
        if (!resetn_in) begin
            tune_to_reference_out <= 1'b0;
            lock_indicator_pin_out <= 1'b0;
            rf_supply_enable_out <= 1'b0;
            fb_scaled <= 1'b0;
        end else begin
            tune_to_reference_out <= band_active | band_start;
            lock_indicator_pin_out <= digital_lock_in & ~band_active;
            // supply held off until digital lock with band selection over when muting
            rf_supply_enable_out <= ~mute_until_locked |
                (digital_lock_in & ~band_active);
            if (fb_tick_in) begin
                fb_scaled <= ~fb_scaled;
            end
        end
    end

    // ****************************************
    // test output multiplexer
    // ****************************************
    reg next_test_output;

    // pick the source for the test pin
    always @* begin
        case (testout_sel)
            `TESTOUT_HIGH: next_test_output = 1'b1;
            `TESTOUT_GND: next_test_output = 1'b0;
            `TESTOUT_REF: next_test_output = ref_scaled;
            `TESTOUT_FB: next_test_output = fb_scaled;
            `TESTOUT_ALOCK: next_test_output = analog_lock_in;
            `TESTOUT_DLOCK: next_test_output = lock_indicator_pin_out;
            default: next_test_output = 1'b0;
        endcase
    end

    // registered test pin
    always @(posedge mclk_in) begin
        if (!resetn_in) begin
            test_output_pin_out <= 1'b0;
        end else begin
            test_output_pin_out <= next_test_output;
        end
    end
endmodule // synth_serial_program_latch
`default_nettype wire

// File: sim/synth_serial_program_latch_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// port-level checks of the programming latches
// ****************************************
module synth_serial_program_latch_checker (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic latch_strobe_in,
    input wire logic ref_tick_in,
    input wire logic digital_lock_in,
    input wire logic [15:0] int_value_out,
    input wire logic [11:0] modulus_out,
    input wire logic [9:0] ref_count_out,
    input wire logic [2:0] output_divider_select_out,
    input wire logic [1:0] output_power_level_out,
    input wire logic aux_power_down_out,
    input wire logic rf_supply_enable_out,
    input wire logic lock_indicator_pin_out,
    input wire logic tune_to_reference_out,
    input wire logic [31:0] control_word_three_out,
    input wire logic [31:0] control_word_five_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);
    logic [15:0] band_ticks;
    // reference ticks seen during one band selection
    always @(posedge mclk_in) begin
        if (!resetn_in || !tune_to_reference_out) begin
            band_ticks <= 16'h0000;
        end else if (ref_tick_in && band_ticks != 16'hffff) begin
            band_ticks <= band_ticks + 16'h0001;
        end
    end
    // strobe rose one edge ago
    sequence strobe_taken;
        $past(latch_strobe_in) && !$past(latch_strobe_in, 2);
    endsequence
    sequence commit_change;
        $changed({int_value_out, modulus_out, ref_count_out});
    endsequence
    a_commit_on_strobe: assert property (commit_change |-> strobe_taken)
        else $error("committed value changed without a strobe");
    a_direct_on_strobe: assert property ($changed({output_divider_select_out,
        output_power_level_out, aux_power_down_out}) |-> strobe_taken)
        else $error("output control changed without a strobe");
    a_raw_on_strobe: assert property ($changed({control_word_three_out,
        control_word_five_out}) |-> strobe_taken)
        else $error("raw word changed without a strobe");
    a_commit_starts_band: assert property (commit_change |-> ##[0:2] tune_to_reference_out)
        else $error("commit did not start band selection");
    a_band_min_len: assert property ($fell(tune_to_reference_out) |-> band_ticks >= 16'h0008)
        else $error("band selection too short");
    a_lock_in_band: assert property (tune_to_reference_out [*2] |-> !lock_indicator_pin_out)
        else $error("lock shown during band selection");
    a_lock_follows: assert property (!digital_lock_in |=> !lock_indicator_pin_out)
        else $error("lock shown while unlocked");
    a_supply_locked: assert property (lock_indicator_pin_out |-> rf_supply_enable_out)
        else $error("supply off while locked");
endmodule // synth_serial_program_latch_checker
bind synth_serial_program_latch synth_serial_program_latch_checker chk (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .latch_strobe_in(latch_strobe_in),
    .ref_tick_in(ref_tick_in), .digital_lock_in(digital_lock_in),
    .int_value_out(int_value_out), .modulus_out(modulus_out), .ref_count_out(ref_count_out),
    .output_divider_select_out(output_divider_select_out),
    .output_power_level_out(output_power_level_out), .aux_power_down_out(aux_power_down_out),
    .rf_supply_enable_out(rf_supply_enable_out), .lock_indicator_pin_out(lock_indicator_pin_out),
    .tune_to_reference_out(tune_to_reference_out),
    .control_word_three_out(control_word_three_out),
    .control_word_five_out(control_word_five_out));
`default_nettype wire

// File: sim/host_serial_link.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// host side of the three-wire programming link
// ****************************************
module host_serial_link (
    input wire logic mclk_in,
    output logic serial_clk_out,
    output logic serial_data_out,
    output logic latch_strobe_out
);
    int gap; // extra cycles per half bit
    initial begin
        gap = 0;
        serial_clk_out = 1'b0;
        serial_data_out = 1'b0;
        latch_strobe_out = 1'b0;
    end
    // one word msb first, clock parked low, then a strobe pulse
    task automatic send_word(input logic [31:0] word);
        for (int i = 31; i >= 0; i--) begin
            @(posedge mclk_in);
            serial_clk_out <= 1'b0;
            serial_data_out <= word[i]; // msb first
            repeat (gap + 1) @(posedge mclk_in);
            serial_clk_out <= 1'b1;
            repeat (gap + 1) @(posedge mclk_in);
        end
        serial_clk_out <= 1'b0;
        serial_data_out <= ~word[0]; // released data shows the inverse
        @(posedge mclk_in);
        latch_strobe_out <= 1'b1;
        repeat (4) @(posedge mclk_in);
        latch_strobe_out <= 1'b0;
    endtask
endmodule // host_serial_link
`default_nettype wire

// File: sim/tb_synth_serial_program_latch.sv
`timescale 1ns/100ps
`default_nettype none
module tb_synth_serial_program_latch;
    logic mclk_in, resetn_in, ref_tick_in, fb_tick_in, digital_lock_in, analog_lock_in;
    logic serial_clk, serial_data, latch_strobe, test_output_pin_out;
    logic [15:0] int_value_out;
    logic [11:0] frac_value_out, modulus_out, phase_out;
    logic [9:0] ref_count_out;
    logic [3:0] charge_current_out;
    logic [2:0] output_divider_select_out, div_act;
    logic [1:0] output_power_level_out, ref_phase;
    logic ref_doubler_out, ref_halve_out, aux_power_down_out, feedback_after_divider_out;
    logic rf_supply_enable_out, lock_indicator_pin_out, tune_to_reference_out;
    logic [31:0] control_word_three_out, control_word_five_out, r;
    logic [31:0] w0, c1, c2, p1, p2, w3, w4, w5;
    logic [140:0] notes[$];
    logic [140:0] note, got;
    logic [138:0] seen_vec;
    int error_cnt = 0, checks_done = 0;
    int seed = 43008;
    int n, rdiv, bdiv;
    assign seen_vec = {int_value_out, frac_value_out, modulus_out, phase_out, ref_count_out,
        ref_doubler_out, ref_halve_out, charge_current_out, output_divider_select_out,
        output_power_level_out, aux_power_down_out, feedback_after_divider_out,
        control_word_three_out, control_word_five_out};
    synth_serial_program_latch dut (.mclk_in(mclk_in), .resetn_in(resetn_in),
        .serial_clk_in(serial_clk), .serial_data_in(serial_data), .latch_strobe_in(latch_strobe),
        .ref_tick_in(ref_tick_in), .fb_tick_in(fb_tick_in), .digital_lock_in(digital_lock_in),
        .analog_lock_in(analog_lock_in), .int_value_out(int_value_out),
        .frac_value_out(frac_value_out), .modulus_out(modulus_out), .phase_out(phase_out),
        .ref_count_out(ref_count_out), .ref_doubler_out(ref_doubler_out),
        .ref_halve_out(ref_halve_out), .charge_current_out(charge_current_out),
        .output_divider_select_out(output_divider_select_out),
        .output_power_level_out(output_power_level_out), .aux_power_down_out(aux_power_down_out),
        .feedback_after_divider_out(feedback_after_divider_out),
        .rf_supply_enable_out(rf_supply_enable_out),
        .lock_indicator_pin_out(lock_indicator_pin_out),
        .tune_to_reference_out(tune_to_reference_out), .test_output_pin_out(test_output_pin_out),
        .control_word_three_out(control_word_three_out),
        .control_word_five_out(control_word_five_out));
    host_serial_link host (.mclk_in(mclk_in), .serial_clk_out(serial_clk),
        .serial_data_out(serial_data), .latch_strobe_out(latch_strobe));
    initial begin
        mclk_in = 1'b0;
        forever #4 mclk_in = ~mclk_in;
    end
    // reference tick every fourth cycle, random feedback ticks
    always @(posedge mclk_in) begin
        ref_phase <= ref_phase + 2'h1;
        ref_tick_in <= (ref_phase == 2'h3);
        fb_tick_in <= 1'($random(seed));
    end
    task automatic check_val(input string what, input logic [138:0] seen,
                             input logic [138:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // expected outputs from the shadow latches
    function automatic logic [138:0] exp_vec();
        return {w0[30:15], w0[14:3], c1[14:3], c1[26:15], c2[23:14], c2[25], c2[24], c2[12:9],
            div_act, w4[4:3], ~w4[8], w4[23], w3, w5};
    endfunction
    task automatic shadow_init();
        {w0, c1, p1, p2, w3, w4, w5} = '0;
        c2 = 32'h0000_4000;
        div_act = 3'h0;
    endtask
    // update shadow, note expected result, send word
    task automatic apply_word(input logic [31:0] w);
        case (w[2:0])
            3'h0: begin // commit buffered values
                w0 = w;
                c1 = p1;
                c2 = p2;
                if (p2[13]) div_act = w4[22:20]; // buffered divider only
            end
            3'h1: p1 = w;
            3'h2: p2 = w;
            3'h3: w3 = w;
            3'h4: begin
                w4 = w;
                if (!p2[13]) div_act = w[22:20]; // direct divider
            end
            3'h5: w5 = w;
            default: ; // codes six and seven ignored
        endcase
        case (p2[28:26])
            3'h1: note[140:139] = 2'b11;
            3'h5: note[140:139] = {1'b1, analog_lock_in};
            3'h0, 3'h2, 3'h6, 3'h7: note[140:139] = 2'b10;
            default: note[140:139] = 2'b00;
        endcase
        note[138:0] = exp_vec();
        notes.push_back(note);
        host.send_word(w);
    endtask
    task automatic wait_tune(input logic lvl, output int cnt);
        cnt = 0;
        for (int c = 0; c < 30000 && tune_to_reference_out !== lvl; c++) begin
            @(negedge mclk_in);
            if (ref_tick_in) cnt++;
        end
        check_val("band wait", tune_to_reference_out, lvl);
    endtask
    // compare once the strobe has dropped
    initial forever begin
        @(negedge latch_strobe);
        @(negedge mclk_in);
        got = notes.pop_front();
        check_val("latches", seen_vec, got[138:0]);
        if (got[140]) check_val("test pin", test_output_pin_out, got[139]);
    end
    initial begin
        repeat (100000) @(posedge mclk_in);
        error_cnt++;
        give_verdict();
    end
    initial begin
        {resetn_in, ref_tick_in, fb_tick_in, ref_phase, digital_lock_in, analog_lock_in} = '0;
        shadow_init();
        repeat (8) @(posedge mclk_in);
        resetn_in <= 1'b1;
        repeat (2) @(negedge mclk_in);
        check_val("reset state", seen_vec, exp_vec());
        check_val("power-up band", tune_to_reference_out, 1'b1);
        $display("test reset done");
        host.gap = 2;
        r = $random(seed);
        apply_word({r[31:3], 3'h1});
        apply_word(32'h0ff4_1402);
        r = $random(seed);
        apply_word({r[31:3], 3'h0}); // commit after buffered writes
        host.gap = 0;
        apply_word(32'h0050_1004);
        apply_word(32'h0ff4_3402);
        apply_word(32'h0020_1004);
        apply_word({r[31:3], 3'h0}); // divider waits for commit
        apply_word({r[31:3], 3'h6});
        apply_word({~r[31:3], 3'h7});
        $display("test buffering done");
        analog_lock_in <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            apply_word({r[31:20], 8'h01, r[11:9], i[2], r[7:5], i[1:0], 3'h4});
            apply_word({r[31:29], i[2:0], r[25:24], 10'h001, r[13:3], 3'h2});
            apply_word({~r[31:3], 3'h3});
            apply_word({r[30:2], 3'h5});
        end
        apply_word({r[31:3], 3'h0});
        $display("test output controls done");
        for (int k = 0; k < 2; k++) begin
            rdiv = k ? 1 : 3;
            bdiv = k ? 255 : 2; // fast pfd gets a large band divider
            apply_word({8'h00, rdiv[9:0], 11'h000, 3'h2});
            apply_word({12'h000, bdiv[7:0], 9'h000, 3'h4});
            wait_tune(1'b0, n);
            apply_word({r[31:3], 3'h0});
            check_val("band start", tune_to_reference_out, 1'b1);
            wait_tune(1'b0, n);
            check_val("band length", (n >= 10 * rdiv * bdiv - rdiv - 2) &&
                (n <= 10 * rdiv * bdiv + rdiv), 1'b1);
        end
        $display("test band select done");
        apply_word(32'h0000_1404);
        apply_word({r[31:3], 3'h0});
        wait_tune(1'b0, n);
        repeat (3) @(negedge mclk_in);
        check_val("muted supply", rf_supply_enable_out, 1'b0);
        check_val("lock pin", lock_indicator_pin_out, 1'b0);
        @(posedge mclk_in) digital_lock_in <= 1'b1;
        repeat (3) @(negedge mclk_in);
        check_val("locked supply", rf_supply_enable_out, 1'b1);
        check_val("lock pin", lock_indicator_pin_out, 1'b1);
        @(posedge mclk_in) digital_lock_in <= 1'b0;
        repeat (3) @(negedge mclk_in);
        check_val("lost supply", rf_supply_enable_out, 1'b0);
        check_val("lock pin", lock_indicator_pin_out, 1'b0);
        apply_word(32'h0000_1004);
        @(negedge mclk_in);
        check_val("unmuted supply", rf_supply_enable_out, 1'b1);
        $display("test mute done");
        @(posedge mclk_in) resetn_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        resetn_in <= 1'b1;
        shadow_init();
        repeat (2) @(negedge mclk_in);
        check_val("second reset", seen_vec, exp_vec());
        check_val("second band", tune_to_reference_out, 1'b1);
        $display("test second reset done");
        give_verdict();
    end
endmodule // tb_synth_serial_program_latch
`default_nettype wire
